// >>> rtl/ctrl_flag_pkg.sv
// Purpose: constants for the control flag bank
// Assumes: 32-bit control words, one core clock
// Notes:   bit positions follow the architectural layout
package ctrl_flag_pkg;
  localparam int unsigned WORD_W    = 32;
  // system control word fields
  localparam int unsigned PROT_BIT  = 0;
  localparam int unsigned MP_BIT    = 1;
  localparam int unsigned EMU_BIT   = 2;
  localparam int unsigned TSW_BIT   = 3;
  localparam int unsigned NE_BIT    = 5;
  localparam int unsigned WP_BIT    = 16;
  localparam int unsigned AM_BIT    = 18;
  localparam int unsigned NW_BIT    = 29;
  localparam int unsigned CD_BIT    = 30;
  localparam int unsigned PG_BIT    = 31;
  // page directory base fields
  localparam int unsigned PWT_BIT   = 3;
  localparam int unsigned PCD_BIT   = 4;
  // feature extension fields
  localparam int unsigned VME_BIT   = 0;
  localparam int unsigned PVI_BIT   = 1;
  localparam int unsigned TSD_BIT   = 2;
  localparam int unsigned DE_BIT    = 3;
  localparam int unsigned PSE_BIT   = 4;
  localparam int unsigned PAE_BIT   = 5;
  localparam int unsigned MCE_BIT   = 6;
  localparam int unsigned PGE_BIT   = 7;
  localparam int unsigned PCE_BIT   = 8;
  // reset values and init masks
  localparam logic [31:0] SYS_RESET  = 32'h6000_0010;
  localparam logic [31:0] PDB_RESET  = 32'h0000_0000;
  localparam logic [31:0] EXT_RESET  = 32'h0000_0000;
  localparam logic [31:0] MP_CLR_MSK = 32'hffff_fffd;
  localparam logic [31:0] EM_NE_MSK  = 32'h0000_0024;
  // numeric control word after init, fault vectors, top privilege level
  localparam logic [15:0] FCW_ABSENT  = 16'hffff;
  localparam logic [15:0] FCW_PRESENT = 16'h037f;
  localparam logic [7:0]  VEC_DEV_NA  = 8'h07;
  localparam logic [7:0]  VEC_UNDEF   = 8'h06;
  localparam logic [7:0]  VEC_MCHK    = 8'h12;
  localparam logic [7:0]  VEC_ALIGN   = 8'h11;
  localparam logic [7:0]  VEC_GPROT   = 8'h0d;
  localparam logic [1:0]  CPL_TOP     = 2'h0;
  // register selects
  typedef enum logic [1:0] {SEL_SYS, SEL_PDB, SEL_EXT, SEL_NONE} creg_sel_t;
  // instruction classes presented for checking
  typedef enum logic [2:0] {
    CLS_NONE, CLS_FLOAT, CLS_WAIT, CLS_PERF, CLS_TSTAMP, CLS_DBG45
  } instr_cls_t;
endpackage

// >>> rtl/fault_prio.sv
// Purpose: picks one fault vector from the raised causes
// Assumes: causes are one-cycle qualified levels
// Notes:   lower index wins
module fault_prio
  import ctrl_flag_pkg::*;
(
  input  wire logic [5:0] cause_i,
  output logic            take_o,
  output logic [7:0]      vec_o
);
  localparam logic [7:0] VEC_TAB [6] =
    '{VEC_GPROT, VEC_UNDEF, VEC_DEV_NA, VEC_DEV_NA, VEC_ALIGN, VEC_MCHK};

  // --------------------------------------------------------------
  // priority pick
  // --------------------------------------------------------------
  always_comb
  begin
    take_o = 1'b0;
    vec_o  = 8'h00;
    for (int i = 5; i >= 0; i--)
    begin
      if (cause_i[i])
      begin
        take_o = 1'b1;
        vec_o  = VEC_TAB[i];
      end
    end
  end
endmodule

// >>> rtl/cpu_control_flag_bank.sv
// Purpose: control register flag bank steering numeric, paging, cache logic
// Assumes: privileged moves are decoded upstream and presented as strobes
// Notes:   fault and pin outputs are registered one cycle after the request
module cpu_control_flag_bank
  import ctrl_flag_pkg::*;
#(
  parameter int unsigned PADDR_W = 36
)
(
  input  wire logic             SYS_CLK_I,
  input  wire logic             RESET_I,
  input  wire logic             CLK_EN_I,
  input  wire logic             MOV_WR_I,
  input  wire logic             MOV_RD_I,
  input  wire logic [1:0]       MOV_SEL_I,
  input  wire logic [31:0]      MOV_WDATA_I,
  input  wire logic [1:0]       CPL_I,
  input  wire logic             FPU_PRESENT_I,
  input  wire logic             INSTR_VALID_I,
  input  wire logic [2:0]       INSTR_CLASS_I,
  input  wire logic             ALIGN_FLAG_I,
  input  wire logic             MISALIGNED_I,
  input  wire logic             V86_MODE_I,
  input  wire logic             TASK_SWITCH_I,
  input  wire logic             MCHK_ERR_I,
  input  wire logic             SUP_WRITE_I,
  input  wire logic             PAGE_USER_RO_I,
  input  wire logic             UNPAGED_CYCLE_I,
  input  wire logic             CACHE_HIT_WRITE_I,
  input  wire logic             INVAL_REQ_I,
  output logic [31:0]           MOV_RDATA_O,
  output logic [15:0]           FCW_INIT_O,
  output logic                  FAULT_O,
  output logic [7:0]            FAULT_VEC_O,
  output logic                  FPU_DISPATCH_O,
  output logic                  WAIT_TEST_TS_O,
  output logic                  FPU_ERR_INTERNAL_O,
  output logic                  PADDR_WIDE_O,
  output logic                  ALT_TABLE_FMT_O,
  output logic                  LARGE_PAGE_OK_O,
  output logic                  LARGE_PAGE_2M_O,
  output logic                  TLB_FLUSH_O,
  output logic                  TLB_KEEP_GLOBAL_O,
  output logic                  INSTR_OK_O,
  output logic                  V86_VINT_O,
  output logic                  PROT_VINT_O,
  output logic                  CACHE_EN_O,
  output logic                  INVAL_ACCEPT_O,
  output logic                  WT_HIT_EXT_O,
  output logic                  WRITE_BLOCK_O,
  output logic                  PAGE_CACHE_DIS_PIN_O,
  output logic                  PAGE_WT_PIN_O
);
  // only the extended width is served; other widths would leave address lines undefined
  if (PADDR_W != 36)
  begin : g_width_check
    $error("PADDR_W must be 36");
  end

  // --------------------------------------------------------------
  // register state
  // --------------------------------------------------------------
  logic [31:0] system_control_word, next_system_control_word;
  logic [31:0] page_directory_base, next_page_directory_base;
  logic [31:0] feature_extension_control, next_feature_extension_control;
  logic        priv_ok;
  logic        mov_priv_fail;

  function automatic logic sel_is(input logic [1:0] s, input creg_sel_t t);
    return s == 2'(t);
  endfunction

  assign priv_ok       = CPL_I == CPL_TOP;
  assign mov_priv_fail = (MOV_WR_I || MOV_RD_I) && !priv_ok;

  // writes land only from privileged moves
  always_comb
  begin
    next_system_control_word       = system_control_word;
    next_page_directory_base       = page_directory_base;
    next_feature_extension_control = feature_extension_control;
    if (MOV_WR_I && priv_ok)
    begin
      if (sel_is(MOV_SEL_I, SEL_SYS))
        next_system_control_word = MOV_WDATA_I;
      if (sel_is(MOV_SEL_I, SEL_PDB))
        next_page_directory_base = MOV_WDATA_I;
      if (sel_is(MOV_SEL_I, SEL_EXT))
        next_feature_extension_control = MOV_WDATA_I;
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      system_control_word       <= SYS_RESET;
      page_directory_base       <= PDB_RESET;
      feature_extension_control <= EXT_RESET;
    end
    else if (CLK_EN_I)
    begin
      system_control_word       <= next_system_control_word;
      page_directory_base       <= next_page_directory_base;
      feature_extension_control <= next_feature_extension_control;
    end
  end

  // --------------------------------------------------------------
  // flag decode
  // --------------------------------------------------------------
  logic prot, paging, emu, mon, tsw, ne, wp, am, nw, cd;
  logic v86_virtual_int_enable, prot_virtual_int_enable, timestamp_disable, de, large_page_enable, address_extension_enable, machine_check_enable, global_page_enable, perf_counter_read_enable;
  assign prot   = system_control_word[PROT_BIT];
  assign paging = system_control_word[PG_BIT];
  assign emu    = system_control_word[EMU_BIT];
  assign mon    = system_control_word[MP_BIT];
  assign tsw    = system_control_word[TSW_BIT];
  assign ne     = system_control_word[NE_BIT];
  assign wp     = system_control_word[WP_BIT];
  assign am     = system_control_word[AM_BIT];
  assign nw     = system_control_word[NW_BIT];
  assign cd     = system_control_word[CD_BIT];
  assign v86_virtual_int_enable    = feature_extension_control[VME_BIT];
  assign prot_virtual_int_enable    = feature_extension_control[PVI_BIT];
  assign timestamp_disable    = feature_extension_control[TSD_BIT];
  assign de     = feature_extension_control[DE_BIT];
  assign large_page_enable    = feature_extension_control[PSE_BIT];
  assign address_extension_enable    = feature_extension_control[PAE_BIT];
  assign machine_check_enable    = feature_extension_control[MCE_BIT];
  assign global_page_enable    = feature_extension_control[PGE_BIT];
  assign perf_counter_read_enable    = feature_extension_control[PCE_BIT];

  // static steering outputs follow the registers and FPU_PRESENT_I directly
  logic pae_act;
  assign pae_act            = address_extension_enable && paging && prot;
  assign PADDR_WIDE_O       = pae_act;
  assign ALT_TABLE_FMT_O    = pae_act;
  assign LARGE_PAGE_OK_O    = large_page_enable && prot;
  assign LARGE_PAGE_2M_O    = large_page_enable && prot && pae_act;
  assign FPU_DISPATCH_O     = !emu;
  assign WAIT_TEST_TS_O     = mon;
  assign FPU_ERR_INTERNAL_O = ne;
  assign V86_VINT_O         = v86_virtual_int_enable;
  assign PROT_VINT_O        = prot_virtual_int_enable;
  assign CACHE_EN_O         = !cd;
  assign FCW_INIT_O         = FPU_PRESENT_I ? FCW_PRESENT : FCW_ABSENT;

  // --------------------------------------------------------------
  // instruction checks and event outputs
  // --------------------------------------------------------------
  logic [5:0] cause;
  logic       take;
  logic [7:0] vec;
  logic       is_flt, is_wait, perf_bad, ts_bad, dbg_bad, wait_trap, align_hit;

  assign is_flt    = INSTR_VALID_I && INSTR_CLASS_I == 3'(CLS_FLOAT);
  assign is_wait   = INSTR_VALID_I && INSTR_CLASS_I == 3'(CLS_WAIT);
  assign perf_bad  = INSTR_VALID_I && INSTR_CLASS_I == 3'(CLS_PERF)
                     && !perf_counter_read_enable && !priv_ok;
  assign ts_bad    = INSTR_VALID_I && INSTR_CLASS_I == 3'(CLS_TSTAMP)
                     && timestamp_disable && !priv_ok;
  assign dbg_bad   = INSTR_VALID_I && INSTR_CLASS_I == 3'(CLS_DBG45) && de;
  assign wait_trap = is_wait && mon && tsw;
  assign align_hit = INSTR_VALID_I && MISALIGNED_I && am && ALIGN_FLAG_I;
  assign cause     = {MCHK_ERR_I && machine_check_enable, align_hit, wait_trap,
                      is_flt && (emu || tsw), dbg_bad,
                      perf_bad || ts_bad || mov_priv_fail};

  fault_prio u_prio
  (
    .cause_i (cause),
    .take_o  (take),
    .vec_o   (vec)
  );

  logic        next_fault, next_ok, next_flush, next_keep, next_inval, next_wt;
  logic        next_wblk, next_pcd, next_pwt;
  logic [7:0]  next_vec;
  logic [31:0] next_rdata;

  // per-request events, all registered one cycle later
  always_comb
  begin
    next_fault = take;
    next_vec   = take ? vec : 8'h00;
    next_ok    = INSTR_VALID_I && !take;
    next_flush = TASK_SWITCH_I || (MOV_WR_I && priv_ok && sel_is(MOV_SEL_I, SEL_PDB));
    next_keep  = next_flush && global_page_enable && prot;
    next_inval = INVAL_REQ_I && !nw;
    next_wt    = CACHE_HIT_WRITE_I && !nw;
    next_wblk  = SUP_WRITE_I && PAGE_USER_RO_I && wp;
    next_pcd   = paging && UNPAGED_CYCLE_I && page_directory_base[PCD_BIT];
    next_pwt   = paging && UNPAGED_CYCLE_I && page_directory_base[PWT_BIT];
    next_rdata = 32'h0000_0000;
    if (MOV_RD_I && priv_ok)
    begin
      unique case (MOV_SEL_I)
        2'(SEL_SYS): next_rdata = system_control_word;
        2'(SEL_PDB): next_rdata = page_directory_base;
        2'(SEL_EXT): next_rdata = feature_extension_control;
        default:     next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      FAULT_O              <= 1'b0;
      FAULT_VEC_O          <= 8'h00;
      INSTR_OK_O           <= 1'b0;
      TLB_FLUSH_O          <= 1'b0;
      TLB_KEEP_GLOBAL_O    <= 1'b0;
      INVAL_ACCEPT_O       <= 1'b0;
      WT_HIT_EXT_O         <= 1'b0;
      WRITE_BLOCK_O        <= 1'b0;
      PAGE_CACHE_DIS_PIN_O <= 1'b0;
      PAGE_WT_PIN_O        <= 1'b0;
      MOV_RDATA_O          <= 32'h0000_0000;
    end
    else if (CLK_EN_I)
    begin
      FAULT_O              <= next_fault;
      FAULT_VEC_O          <= next_vec;
      INSTR_OK_O           <= next_ok;
      TLB_FLUSH_O          <= next_flush;
      TLB_KEEP_GLOBAL_O    <= next_keep;
      INVAL_ACCEPT_O       <= next_inval;
      WT_HIT_EXT_O         <= next_wt;
      WRITE_BLOCK_O        <= next_wblk;
      PAGE_CACHE_DIS_PIN_O <= next_pcd;
      PAGE_WT_PIN_O        <= next_pwt;
      MOV_RDATA_O          <= next_rdata;
    end
  end

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  // event outputs are registered, so their checks look one cycle after the cause

  emu_trap_vec_a: assert property (CLK_EN_I && is_flt && emu && !cause[0] && !cause[1]
    |=> FAULT_O && FAULT_VEC_O == VEC_DEV_NA)
    else $error("emulated float did not raise vector 7");
  ext_reset_zero_a: assert property ($fell(RESET_I)
    |-> feature_extension_control == EXT_RESET)
    else $error("extension register not zero after reset");
  wide_addr_a: assert property (PADDR_WIDE_O |-> paging && prot && address_extension_enable)
    else $error("wide address without paging");
  tsd_block_a: assert property (CLK_EN_I && ts_bad
    |=> FAULT_O && FAULT_VEC_O == VEC_GPROT)
    else $error("timestamp read not blocked");
  dbg_undef_a: assert property (CLK_EN_I && dbg_bad && !cause[0]
    |=> FAULT_VEC_O == VEC_UNDEF) else $error("debug reg access not undefined");
  global_keep_a: assert property (TLB_KEEP_GLOBAL_O |-> TLB_FLUSH_O)
    else $error("global keep without flush");
  pin_drive_a: assert property (CLK_EN_I && paging && UNPAGED_CYCLE_I
    |=> PAGE_CACHE_DIS_PIN_O == $past(page_directory_base[PCD_BIT]))
    else $error("page cache pin mismatch");
  priv_write_a: assert property (CLK_EN_I && MOV_WR_I && !priv_ok
    |=> $stable(system_control_word) && $stable(feature_extension_control))
    else $error("unprivileged write changed register");
  wait_ts_a: assert property (CLK_EN_I && is_wait && !mon
    |=> !FAULT_O || FAULT_VEC_O != VEC_DEV_NA)
    else $error("wait trapped with monitor clear");
  align_gate_a: assert property (CLK_EN_I && INSTR_VALID_I && !align_hit
    |=> FAULT_VEC_O != VEC_ALIGN)
    else $error("alignment fault without mask and flag");

  emu_cov: cover property (is_flt && emu);
  flush_cov: cover property (TLB_KEEP_GLOBAL_O);
  pin_cov: cover property (PAGE_WT_PIN_O);
  // fault kinds reached by the directed scenarios
  align_cov: cover property (FAULT_VEC_O == VEC_ALIGN);
  mchk_cov: cover property (FAULT_VEC_O == VEC_MCHK);
endmodule

// >>> testbench/cpu_control_flag_bank_bench.sv
// Purpose: directed bench for the control flag bank
// Assumes: inputs change on the falling edge, registered results one cycle later
// Notes:   V86_MODE_I is tied low; no open wait, a watchdog ends a hang
module cpu_control_flag_bank_bench
  import ctrl_flag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, clk_en, mov_wr, mov_rd, fpu_pr, iv, alf, mis, tsw, mchk;
  logic        supw, uro, unp, hitw, inval, flt, ok;
  logic [1:0]  sel, cpl;
  logic [2:0]  cls;
  logic [31:0] wdata, rdata, q;
  logic [15:0] fcw;
  logic [7:0]  fvec, vec;
  logic        disp, wts, ferr, pwide, alt, lpok, lp2m, flush, keep, iok, v86v, protv;
  logic        cen, iacc, wth, wblk, pcdp, pwtp;
  int          err_count = 0;
  int          checks = 0;
  localparam logic [31:0] PE = 32'h1 << PROT_BIT;
  localparam logic [31:0] PGPE = (32'h1 << PG_BIT) | PE;

  cpu_control_flag_bank i_dut (
    .SYS_CLK_I(clk), .RESET_I(rst), .CLK_EN_I(clk_en), .MOV_WR_I(mov_wr),
    .MOV_RD_I(mov_rd), .MOV_SEL_I(sel), .MOV_WDATA_I(wdata), .CPL_I(cpl),
    .FPU_PRESENT_I(fpu_pr), .INSTR_VALID_I(iv), .INSTR_CLASS_I(cls), .ALIGN_FLAG_I(alf),
    .MISALIGNED_I(mis), .V86_MODE_I(1'b0), .TASK_SWITCH_I(tsw), .MCHK_ERR_I(mchk),
    .SUP_WRITE_I(supw), .PAGE_USER_RO_I(uro), .UNPAGED_CYCLE_I(unp),
    .CACHE_HIT_WRITE_I(hitw), .INVAL_REQ_I(inval), .MOV_RDATA_O(rdata), .FCW_INIT_O(fcw),
    .FAULT_O(flt), .FAULT_VEC_O(fvec), .FPU_DISPATCH_O(disp), .WAIT_TEST_TS_O(wts),
    .FPU_ERR_INTERNAL_O(ferr), .PADDR_WIDE_O(pwide), .ALT_TABLE_FMT_O(alt),
    .LARGE_PAGE_OK_O(lpok), .LARGE_PAGE_2M_O(lp2m), .TLB_FLUSH_O(flush),
    .TLB_KEEP_GLOBAL_O(keep), .INSTR_OK_O(iok), .V86_VINT_O(v86v), .PROT_VINT_O(protv),
    .CACHE_EN_O(cen), .INVAL_ACCEPT_O(iacc), .WT_HIT_EXT_O(wth), .WRITE_BLOCK_O(wblk),
    .PAGE_CACHE_DIS_PIN_O(pcdp), .PAGE_WT_PIN_O(pwtp)
  );

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic step();
    @(negedge clk);
  endtask

  // one move cycle; the fault it raises stands only in the following cycle
  task automatic wr(input logic [1:0] s, input logic [31:0] d);
    sel = s; wdata = d; mov_wr = 1'b1; step(); vec = fvec; ok = flt; mov_wr = 1'b0; step();
  endtask

  task automatic rd(input logic [1:0] s);
    sel = s; mov_rd = 1'b1; step(); q = rdata; mov_rd = 1'b0; step();
  endtask

  task automatic ins(input logic [2:0] c);
    cls = c; iv = 1'b1; step(); vec = fvec; ok = flt; q = {31'h0, iok}; iv = 1'b0; step();
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(SEL_EXT); chk("ext reset", q, EXT_RESET);
    rd(SEL_SYS); chk("sys reset", q, SYS_RESET);
    chk("cache off", cen, 1'b0);
  endtask

  task automatic t_numeric();
    fpu_pr = 1'b0; step(); chk("fcw absent", fcw, FCW_ABSENT);
    fpu_pr = 1'b1; step(); chk("fcw present", fcw, FCW_PRESENT);
    wr(SEL_SYS, SYS_RESET | 32'h2); chk("wait ts on", wts, 1'b1);
    wr(SEL_SYS, ((SYS_RESET | 32'h2) & MP_CLR_MSK) | EM_NE_MSK);
    rd(SEL_SYS); chk("init word", q, SYS_RESET | 32'h24);
    chk("dispatch off", disp, 1'b0);
    chk("err internal", ferr, 1'b1);
    ins(CLS_FLOAT); chk("float trap", ok, 1'b1);
    chk("float vec", vec, VEC_DEV_NA);
    wr(SEL_SYS, SYS_RESET); ins(CLS_FLOAT); chk("float pass", ok, 1'b0);
    chk("dispatch on", disp, 1'b1);
    wr(SEL_SYS, SYS_RESET | 32'ha); ins(CLS_WAIT); chk("wait trap", ok, 1'b1);
    chk("wait vec", vec, VEC_DEV_NA);
    wr(SEL_SYS, SYS_RESET | 32'h8); ins(CLS_WAIT); chk("wait ignore", ok, 1'b0);
  endtask

  // paging extras need protected mode, the wide table also needs paging
  task automatic t_paging();
    wr(SEL_SYS, PE); wr(SEL_EXT, 32'h30);
    chk("alt no paging", alt, 1'b0);
    chk("large ok", lpok, 1'b1);
    wr(SEL_SYS, PGPE); chk("wide", pwide, 1'b1);
    chk("alt paging", alt, 1'b1);
    chk("2m pages", lp2m, 1'b1);
    wr(SEL_EXT, 32'h10); chk("narrow", pwide, 1'b0);
    chk("4m pages", lp2m, 1'b0);
    wr(SEL_SYS, SYS_RESET); chk("real mode", lpok, 1'b0);
  endtask

  task automatic t_instr();
    wr(SEL_SYS, PE); wr(SEL_EXT, 32'h0); cpl = 2'h3;
    ins(CLS_PERF); chk("perf refused", vec, VEC_GPROT);
    cpl = 2'h0; wr(SEL_EXT, 32'h100); cpl = 2'h3;
    ins(CLS_PERF); chk("perf any level", q, 32'h1);
    cpl = 2'h0; wr(SEL_EXT, 32'h4); cpl = 2'h3;
    ins(CLS_TSTAMP); chk("tstamp user", q, 32'h0);
    cpl = 2'h0; ins(CLS_TSTAMP); chk("tstamp top", q, 32'h1);
    wr(SEL_EXT, 32'h8); ins(CLS_DBG45); chk("dbg undef", vec, VEC_UNDEF);
    wr(SEL_EXT, 32'h0); ins(CLS_DBG45); chk("dbg alias", ok, 1'b0);
  endtask

  task automatic t_priv();
    wr(SEL_EXT, 32'h1); cpl = 2'h3;
    wr(SEL_EXT, 32'h1ff); chk("user move vec", vec, VEC_GPROT);
    rd(SEL_EXT); chk("user read", q, 32'h0);
    cpl = 2'h0; rd(SEL_EXT); chk("kept", q, 32'h1);
    clk_en = 1'b0; wr(SEL_EXT, 32'h2); clk_en = 1'b1;
    rd(SEL_EXT); chk("frozen", q, 32'h1);
    chk("v86 vint", v86v, 1'b1);
    wr(SEL_EXT, 32'h2); chk("prot vint", protv, 1'b1);
  endtask

  task automatic t_levels();
    wr(SEL_SYS, PGPE); wr(SEL_EXT, 32'h80); tsw = 1'b1; step();
    chk("flush", flush, 1'b1);
    chk("keep global", keep, 1'b1);
    tsw = 1'b0; wr(SEL_EXT, 32'h0); tsw = 1'b1; step();
    chk("no keep", keep, 1'b0);
    tsw = 1'b0; wr(SEL_PDB, 32'h18); unp = 1'b1; step();
    chk("pcd pin", pcdp, 1'b1);
    chk("pwt pin", pwtp, 1'b1);
    unp = 1'b0; wr(SEL_SYS, PE | (32'h1 << WP_BIT)); supw = 1'b1; uro = 1'b1; step();
    chk("wp block", wblk, 1'b1);
    supw = 1'b0; wr(SEL_SYS, PE); supw = 1'b1; step();
    chk("wp off", wblk, 1'b0);
    supw = 1'b0; hitw = 1'b1; inval = 1'b1; step();
    chk("cache on", cen, 1'b1);
    chk("inval ok", iacc, 1'b1);
    chk("wt hit", wth, 1'b1);
    wr(SEL_SYS, PE | 32'h6000_0000); step();
    chk("inval cut", iacc, 1'b0);
    chk("wt cut", wth, 1'b0);
    hitw = 1'b0; inval = 1'b0; wr(SEL_SYS, PE | (32'h1 << AM_BIT));
    cls = CLS_NONE; cpl = 2'h3; iv = 1'b1; alf = 1'b1; mis = 1'b1; step();
    chk("align vec", fvec, VEC_ALIGN);
    alf = 1'b0; step(); step(); chk("align flag off", flt, 1'b0);
    iv = 1'b0; mis = 1'b0; cpl = 2'h0; wr(SEL_EXT, 32'h40); mchk = 1'b1; step();
    chk("mchk vec", fvec, VEC_MCHK);
    mchk = 1'b0; wr(SEL_EXT, 32'h0); mchk = 1'b1; step();
    chk("mchk gated", flt, 1'b0);
    mchk = 1'b0; step();
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    {rst, clk_en, mov_wr, mov_rd, fpu_pr, iv, alf, mis, tsw, mchk} = 10'h300;
    {supw, uro, unp, hitw, inval, sel, cpl, cls, wdata} = '0;
    rst = 1'b1;
    repeat (5) step();
    rst = 1'b0;
    t_reset();
    t_numeric();
    t_paging();
    t_instr();
    t_priv();
    t_levels();
    finish_test();
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    finish_test();
  end
endmodule
